// ---- design/vfc_core.sv ----
`timescale 1ns/1ps
module vfc_core
  import vfc_pkg::*;
#(
  parameter int IN_W = 16,
  parameter int REF_CODE = REF_CODE_DEF,
  parameter int VREF_MV = VREF_MV_DEF,
  parameter int VDD_MV = VDD_MV_DEF,
  parameter int PD_CYCLES = PD_CYCLES_DEF
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // converter pins
  input wire logic i_master_clock_in,
  input wire logic i_buf_select,
  input wire logic signed [IN_W-1:0] i_analog_input,
  // outputs
  output logic o_freq_pulse_out,
  output logic o_inverted_clock_out,
  output logic o_power_down
);

  localparam int MOD = RATE_DEN * REF_CODE;
  localparam int ACC_W = $clog2(MOD) + 2;
  localparam int CNT_W = $clog2(PD_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic int mv_to_code(input int mv);
    mv_to_code = (mv * REF_CODE) / VREF_MV;
  endfunction

  function automatic int clamp_int(input int x, input int lo, input int hi);
    if (x < lo) begin
      clamp_int = lo;
    end else if (x > hi) begin
      clamp_int = hi;
    end else begin
      clamp_int = x;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta;
  logic rst_sync;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic clk_meta;
  logic clk_sync;
  logic clk_prev;
  logic buf_meta;
  logic buf_sync;
  logic signed [IN_W-1:0] vin_meta;
  logic signed [IN_W-1:0] vin_sync;

  always_ff @(posedge i_mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      clk_meta <= 1'b0;
      clk_sync <= 1'b0;
      clk_prev <= 1'b0;
      buf_meta <= 1'b0;
      buf_sync <= 1'b0;
      vin_meta <= '0;
      vin_sync <= '0;
    end else begin
      clk_meta <= i_master_clock_in;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
      buf_meta <= i_buf_select;
      buf_sync <= buf_meta;
      vin_meta <= i_analog_input;
      vin_sync <= vin_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // modulator

  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] next_acc;
  logic pulse;
  logic next_pulse;
  logic freq_pulse_out;
  logic next_freq_pulse_out;
  logic inv_clk;
  logic next_inv_clk;
  logic [CNT_W-1:0] low_cnt;
  logic [CNT_W-1:0] next_low_cnt;
  logic pd;
  logic next_pd;
  logic rise;

  assign rise = clk_sync & ~clk_prev;

  always_comb begin
    int lo;
    int hi;
    int code;
    int inc;
    int sum;
    lo = 0;
    hi = 0;
    code = 0;
    inc = 0;
    sum = 0;
    next_acc = acc;
    next_pulse = pulse & clk_sync;
    next_low_cnt = low_cnt;
    next_pd = pd;
    // input range by buffer mode
    if (buf_sync) begin
      lo = mv_to_code(BUF_LO_MV);
      hi = mv_to_code(VDD_MV - BUF_HI_MARGIN_MV);
    end else begin
      lo = mv_to_code(UNBUF_LO_MV);
      hi = mv_to_code(VDD_MV + UNBUF_HI_MARGIN_MV);
    end
    code = clamp_int(int'(vin_sync), lo, hi);
    inc = ZERO_RATE_TENTHS * REF_CODE + SPAN_TENTHS * code;
    inc = clamp_int(inc, 1, MOD - 1);
    sum = int'(acc) + inc;
    // one step per master clock rising edge, none on the edge that ends power-down
    if (rise && !pd) begin
      if (sum >= MOD) begin
        next_acc = ACC_W'(sum - MOD);
        next_pulse = 1'b1;
      end else begin
        next_acc = ACC_W'(sum);
        next_pulse = 1'b0;
      end
    end
    // power-down on a stopped-low master clock
    if (clk_sync) begin
      next_low_cnt = '0;
      next_pd = 1'b0;
    end else if (int'(low_cnt) < PD_CYCLES) begin
      next_low_cnt = low_cnt + CNT_W'(1);
    end else begin
      next_pd = 1'b1;
      next_pulse = 1'b0;
    end
    next_freq_pulse_out = next_pulse | next_pd;
    next_inv_clk = ~clk_sync;
  end

  always_ff @(posedge i_mclk or negedge rst_sync) begin
    if (!rst_sync) begin
      acc <= '0;
      pulse <= 1'b0;
      freq_pulse_out <= 1'b0;
      inv_clk <= 1'b1;
      low_cnt <= '0;
      pd <= 1'b0;
    end else begin
      acc <= next_acc;
      pulse <= next_pulse;
      freq_pulse_out <= next_freq_pulse_out;
      inv_clk <= next_inv_clk;
      low_cnt <= next_low_cnt;
      pd <= next_pd;
    end
  end

  assign o_freq_pulse_out = freq_pulse_out;
  assign o_inverted_clock_out = inv_clk;
  assign o_power_down = pd;

endmodule

// ---- design/vfc_pkg.sv ----
// Summary of operation
// - average pulse rate is clock times 0.1 plus 0.8 times input over reference
// - full-scale input gives 0.9 of clock rate, zero input gives 0.1
// - each pulse lasts exactly the high phase of the master clock
// - outside power-down, pulses only ever begin on a rising master clock edge
// - buffer select high limits input to 0.1 V up to supply minus 0.2 V
// - buffer select low allows 0.15 V below ground to 0.15 V above supply
// - buffered mode at 2.5 V reference bottoms out at 13.2% of clock rate
// - spacing varies pulse to pulse; at 3/10 it runs three, three, four
// - input sampled every master clock in a one-bit charge-balance loop
// - an inverted copy of the master clock is driven out
// - master clock low about 1 ms enters power-down, pulse output held high
package vfc_pkg;

  // transfer function, in tenths of master clock rate
  localparam int RATE_DEN = 10;
  localparam int ZERO_RATE_TENTHS = 1;
  localparam int SPAN_TENTHS = 8;

  // reference and supply defaults, millivolts; reference code in counts
  localparam int VREF_MV_DEF = 2500;
  localparam int VDD_MV_DEF = 5000;
  localparam int REF_CODE_DEF = 4096;

  // input limits, millivolts
  localparam int UNBUF_LO_MV = -150;
  localparam int UNBUF_HI_MARGIN_MV = 150;
  localparam int BUF_LO_MV = 100;
  localparam int BUF_HI_MARGIN_MV = 200;

  // power-down timing
  localparam int MCLK_HZ = 25000000;
  localparam int PD_TIME_US = 1000;
  localparam int PD_CYCLES_DEF = PD_TIME_US * (MCLK_HZ / 1000000);

endpackage

// ---- testbench/tb_synchronous_vfc_pulse_output.sv ----
`timescale 1ns/1ps
module tb_synchronous_vfc_pulse_output;
  import vfc_pkg::*;
  localparam int PD = 50;
  localparam int NMC = 80;
  logic i_mclk = 0, i_nrst = 0, mc_run = 0, i_buf_select = 0;
  logic gate = 0, clr = 0;
  logic [2:0] ph = 3'h0;
  logic signed [15:0] i_analog_input = 16'sh0000;
  logic o_freq_pulse_out, o_inverted_clock_out, o_power_down;
  logic [15:0] cnt;
  logic [31:0] xs = 32'h0000003E;
  int n_mismatch = 0, n_compared = 0, cyc = 0;
  wire i_master_clock_in = mc_run & ph[2];
  always #20 i_mclk = ~i_mclk;
  always @(negedge i_mclk) if (mc_run) ph <= ph + 3'h1;
  vfc_core #(.PD_CYCLES(PD)) i_dut (.i_mclk(i_mclk), .i_nrst(i_nrst),
    .i_master_clock_in(i_master_clock_in), .i_buf_select(i_buf_select),
    .i_analog_input(i_analog_input), .o_freq_pulse_out(o_freq_pulse_out),
    .o_inverted_clock_out(o_inverted_clock_out),
    .o_power_down(o_power_down));
  vfc_pulse_counter i_rx (.i_mclk(i_mclk), .i_clear(clr), .i_gate(gate),
    .i_pulse(o_freq_pulse_out), .o_count(cnt));
  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    xs ^= xs << 13;
    xs ^= xs >> 17;
    xs ^= xs << 5;
    return xs;
  endfunction
  function automatic logic [15:0] exp_cnt(int c, logic b);
    int lo;
    lo = (b ? BUF_LO_MV : UNBUF_LO_MV) * REF_CODE_DEF / VREF_MV_DEF;
    if (c < lo) c = lo;
    return 16'(NMC * (ZERO_RATE_TENTHS * REF_CODE_DEF + SPAN_TENTHS * c)
      / (RATE_DEN * REF_CODE_DEF));
  endfunction
  task automatic check(string nm, logic [15:0] e, logic [15:0] s, bit t);
    n_compared++;
    if (s !== e && !(t && s === e + 16'h0001)) begin
      n_mismatch++;
      $display("wrong value %s exp %0d seen %0d", nm, e, s);
    end
  endtask
  task automatic run_case(logic signed [15:0] c, logic b);
    i_analog_input = c;
    i_buf_select = b;
    repeat (32) @(negedge i_mclk);
    clr = 1;
    @(negedge i_mclk);
    clr = 0;
    gate = 1;
    repeat (NMC * 8) @(negedge i_mclk);
    gate = 0;
    @(negedge i_mclk);
    check("pulse count", exp_cnt(c, b), cnt, 1);
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 12000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(negedge i_mclk);
    check("clock out in reset", 16'h1, 16'(o_inverted_clock_out), 0);
    i_nrst = 1;
    mc_run = 1;
    run_case(16'sh0000, 0);
    run_case(16'sh1000, 0);
    run_case(16'sh0400, 0);
    run_case(16'sh0000, 1);
    run_case(-16'sh0100, 0);
    run_case(16'sh00A3, 1);
    repeat (6) run_case(16'(163 + rnd() % 3933), 1'(rnd()));
    mc_run = 0;
    repeat (PD + 20) @(negedge i_mclk);
    check("power down", 16'h1, 16'(o_power_down), 0);
    check("pulse held", 16'h1, 16'(o_freq_pulse_out), 0);
    mc_run = 1;
    repeat (16) @(negedge i_mclk);
    check("power down exit", 16'h0, 16'(o_power_down), 0);
    tally_and_finish();
  end
endmodule
bind vfc_core vfc_asserts #(.PD_CYCLES(PD_CYCLES)) i_chk (.*);

// ---- testbench/vfc_asserts.sv ----
`timescale 1ns/1ps
module vfc_asserts #(
  parameter int PD_CYCLES = 50
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // watched pins
  input wire logic i_master_clock_in,
  input wire logic o_freq_pulse_out,
  input wire logic o_inverted_clock_out,
  input wire logic o_power_down
);
  int lo_cnt;
  always_ff @(posedge i_mclk) begin
    lo_cnt <= (i_master_clock_in || !i_nrst) ? 0 : lo_cnt + 1;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  inv_clock_a: assert property ($rose(i_master_clock_in) |-> ##[1:4]
    !o_inverted_clock_out) else $error("clock out not inverted");
  pulse_edge_a: assert property ($rose(o_freq_pulse_out) &&
    !o_power_down |-> !o_inverted_clock_out) else $error("pulse off edge");
  pulse_delay_a: assert property ($rose(o_freq_pulse_out) &&
    !o_power_down |-> $past(i_master_clock_in, 3)) else $error("pulse late");
  pulse_width_a: assert property ($rose(o_inverted_clock_out)
    |-> ##[0:2] !o_freq_pulse_out) else $error("pulse too wide");
  pulse_gap_a: assert property ($fell(o_freq_pulse_out) &&
    !$past(o_power_down) |-> !o_freq_pulse_out[*3])
    else $error("pulses back to back");
  pd_hold_a: assert property (o_power_down |-> o_freq_pulse_out)
    else $error("pulse low in power down");
  pd_entry_a: assert property (lo_cnt == PD_CYCLES + 8
    |-> o_power_down) else $error("no power down");
  pd_exit_a: assert property ($rose(i_master_clock_in) |-> ##[1:5]
    !o_power_down) else $error("power down stuck");
endmodule

// ---- testbench/vfc_pulse_counter.sv ----
`timescale 1ns/1ps
module vfc_pulse_counter (
  // clock and control
  input wire logic i_mclk,
  input wire logic i_clear,
  input wire logic i_gate,
  // pulse train
  input wire logic i_pulse,
  output logic [15:0] o_count
);
  logic prev;
  always_ff @(posedge i_mclk) begin
    prev <= i_pulse;
    if (i_clear) begin
      o_count <= 16'h0000;
    end else if (i_gate && i_pulse && !prev) begin
      o_count <= o_count + 16'h0001;
    end
  end
endmodule
